// file: core/byte_fifo.sv
`default_nettype none

module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [15:0] level
);

  localparam int AW = $clog2(DEPTH);

  // Pointers need a power-of-two depth
  if (DEPTH < 2 || (1 << AW) != DEPTH || DEPTH > 32768) begin : g_bad_depth
    $error("byte_fifo: DEPTH must be a power of two from 2 to 32768");
  end

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW:0] wr_ptr_ff;
  logic [AW:0] rd_ptr_ff;
  logic [AW:0] used;
  logic push;
  logic pop;

  // Honest flags from pointer distance
  assign used = wr_ptr_ff - rd_ptr_ff;
  assign in_ready = (used != DEPTH[AW:0]);
  assign out_valid = (used != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_ff[rd_ptr_ff[AW-1:0]];
  assign level = 16'(used);

  // Storage
  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem_ff[wr_ptr_ff[AW-1:0]] <= in_data;
    end
  end

  // Pointers
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      if (pop)
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
    end
  end

endmodule : byte_fifo

`default_nettype wire

// file: core/tcp_reg_bank.sv
`default_nettype none

module tcp_reg_bank (
  input wire logic clk,
  input wire logic rst,
  input wire logic [tcp_stream_pkg::REG_AW-1:0] addr,
  input wire logic [tcp_stream_pkg::REG_DW-1:0] wdata,
  input wire logic write,
  input wire logic read,
  input wire tcp_stream_pkg::status_t stat,
  input wire logic [31:0] tx_bytes,
  input wire logic [31:0] rx_bytes,
  output logic [tcp_stream_pkg::REG_DW-1:0] rdata,
  output tcp_stream_pkg::config_t cfg,
  output logic ovf_clear
);
  import tcp_stream_pkg::*;

  logic [4:0] width_ff;
  logic [15:0] mss_ff;
  logic [REG_DW-1:0] nxt_rdata;
  logic [REG_DW-1:0] rdata_ff;
  logic [4:0] wr_width;

  assign cfg.wc_width = width_ff;
  assign cfg.mss = mss_ff;
  assign rdata = rdata_ff;
  assign wr_width = wdata[CTRL_WIDTH_LSB +: CTRL_WIDTH_W];
  // Write one to the overflow bit clears it
  assign ovf_clear = write && (addr == OFS_STATUS) && wdata[STAT_OVF_BIT];

  // Software writes, width kept within 1..16
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      width_ff <= CTRL_WIDTH_RST;
      mss_ff <= MSS_RST;
    end
    else if (write)
    begin
      if (addr == OFS_CTRL)
        width_ff <= (wr_width > CTRL_WIDTH_MAX) ? CTRL_WIDTH_MAX :
                    (wr_width < CTRL_WIDTH_MIN) ? CTRL_WIDTH_MIN : wr_width;
      if (addr == OFS_MSS)
        mss_ff <= wdata[15:0];
    end
  end

  // Read decode, unmapped reads zero
  always_comb
  begin
    nxt_rdata = '0;
    case (addr)
      OFS_CTRL: nxt_rdata[CTRL_WIDTH_LSB +: CTRL_WIDTH_W] = width_ff;
      OFS_MSS: nxt_rdata[15:0] = mss_ff;
      OFS_STATUS:
      begin
        nxt_rdata[STAT_STATE_LSB +: 3] = stat.state;
        nxt_rdata[STAT_OPEN_BIT] = stat.open;
        nxt_rdata[STAT_CLOSE_BIT] = stat.close_req;
        nxt_rdata[STAT_OVF_BIT] = stat.tx_overflow;
        nxt_rdata[STAT_LEVEL_LSB +: 16] = stat.tx_level;
      end
      OFS_TX_BYTES: nxt_rdata = tx_bytes;
      OFS_RX_BYTES: nxt_rdata = rx_bytes;
      default: nxt_rdata = '0;
    endcase
  end

  // Read data stands one cycle only
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rdata_ff <= '0;
    else
      rdata_ff <= read ? nxt_rdata : '0;
  end

endmodule : tcp_reg_bank

`default_nettype wire

// file: core/tcp_stream_pkg.sv
`default_nettype none

package tcp_stream_pkg;

  // Data path widths
  localparam int BYTE_W = 8;
  localparam int CNT_W = 16;
  localparam int REG_AW = 8;
  localparam int REG_DW = 32;

  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_MSS = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_TX_BYTES = 8'h0C;
  localparam logic [7:0] OFS_RX_BYTES = 8'h10;

  // Field positions and reset values
  localparam int CTRL_WIDTH_LSB = 0;
  localparam int CTRL_WIDTH_W = 5;
  localparam logic [4:0] CTRL_WIDTH_RST = 5'h10;
  localparam logic [4:0] CTRL_WIDTH_MAX = 5'h10;
  localparam logic [4:0] CTRL_WIDTH_MIN = 5'h01;
  localparam logic [15:0] MSS_RST = 16'h05B4;
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_OPEN_BIT = 4;
  localparam int STAT_CLOSE_BIT = 5;
  localparam int STAT_OVF_BIT = 6;
  localparam int STAT_LEVEL_LSB = 16;

  // Timing counts in clock cycles
  localparam int TX_STOP_CLOCKS = 8;
  localparam int WC_LAG_CLOCKS = 8;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_OPEN = 3'b001,
    ST_DROP = 3'b010,
    ST_CLOSE_WAIT = 3'b011,
    ST_DRAIN = 3'b100,
    ST_LAST = 3'b101
  } conn_state_t;

  typedef struct packed {
    logic [15:0] tx_level;
    logic tx_overflow;
    logic close_req;
    logic open;
    conn_state_t state;
  } status_t;

  typedef struct packed {
    logic [4:0] wc_width;
    logic [15:0] mss;
  } config_t;

endpackage : tcp_stream_pkg

`default_nettype wire

// file: core/tcp_user_stream.sv
// The implementer's own choices: the strobed register port and the address map.
`default_nettype none

module tcp_user_stream #(
  parameter int TX_DEPTH = 64,
  parameter int RX_DEPTH = 8
) (
  input wire logic CLK_SYS,
  input wire logic RST,
  // User side
  output logic CONNECTION_OPEN,
  output logic CLOSE_REQUEST,
  input wire logic CLOSE_RESPONSE,
  input wire logic [7:0] TX_BYTE,
  input wire logic TX_WRITE,
  output logic TX_BUFFER_FULL,
  output logic [7:0] RX_BYTE,
  output logic RX_VALID,
  input wire logic [15:0] RX_STORED_COUNT,
  // Protocol engine side
  input wire logic NET_ESTABLISHED,
  input wire logic NET_FIN_RECEIVED,
  output logic NET_FIN_SEND,
  input wire logic NET_FIN_ACKED,
  output logic [7:0] NET_TX_DATA,
  output logic NET_TX_VALID,
  input wire logic NET_TX_READY,
  input wire logic [7:0] NET_RX_DATA,
  input wire logic NET_RX_VALID,
  output logic NET_RX_READY,
  output logic [15:0] NET_RX_WINDOW,
  output logic [15:0] NET_MSS,
  // Register port
  input wire logic [tcp_stream_pkg::REG_AW-1:0] REG_ADDR,
  input wire logic [tcp_stream_pkg::REG_DW-1:0] REG_WDATA,
  input wire logic REG_WRITE,
  input wire logic REG_READ,
  output logic [tcp_stream_pkg::REG_DW-1:0] REG_RDATA
);
  import tcp_stream_pkg::*;

  // Full must leave room for late writes
  localparam int FULL_MARGIN = TX_STOP_CLOCKS + 2;
  localparam logic [15:0] FULL_LEVEL = 16'(TX_DEPTH - FULL_MARGIN);

  if (TX_DEPTH < 2 * FULL_MARGIN) begin : g_bad_tx
    $error("tcp_user_stream: TX_DEPTH too small for write stop margin");
  end
  if (RX_DEPTH < 2) begin : g_bad_rx
    $error("tcp_user_stream: RX_DEPTH must be at least 2");
  end

  conn_state_t state_ff;
  conn_state_t nxt_state;
  logic open_ff;
  logic close_req_ff;
  logic fin_ff;
  logic tx_full_ff;
  logic tx_ovf_ff;
  logic [7:0] rx_byte_ff;
  logic rx_valid_ff;
  logic [WC_LAG_CLOCKS-1:0] rx_hist_ff;
  logic [15:0] window_ff;
  logic [31:0] tx_bytes_ff;
  logic [31:0] rx_bytes_ff;

  logic tx_accept;
  logic tx_in_ready;
  logic tx_out_valid;
  logic tx_pop;
  logic [7:0] tx_out_data;
  logic [15:0] tx_level;
  logic tx_empty;
  logic rx_out_valid;
  logic rx_out_ready;
  logic [7:0] rx_out_data;
  logic [15:0] rx_level;
  logic rx_release;
  logic [15:0] wc_mask;
  logic [15:0] wc_stored;
  logic [17:0] used_total;
  logic [15:0] nxt_window;
  logic ovf_clear;
  config_t cfg;
  status_t stat;

  // Mask of count bits in use for a given width
  function automatic logic [15:0] width_mask(input logic [4:0] w);
    logic [16:0] one_hot;
    one_hot = 17'h00001 << w;
    width_mask = 16'(one_hot - 17'h00001);
  endfunction : width_mask

  // Count of set bits in the recent release history
  function automatic logic [4:0] ones(input logic [WC_LAG_CLOCKS-1:0] v);
    logic [4:0] n;
    n = '0;
    for (int i = 0; i < WC_LAG_CLOCKS; i++)
      n = n + 5'(v[i]);
    ones = n;
  endfunction : ones

  // Connection state: open, teardown, drain, final confirmation
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE:
      begin
        if (NET_ESTABLISHED)
          nxt_state = ST_OPEN;
      end
      ST_OPEN:
      begin
        if (NET_FIN_RECEIVED)
          nxt_state = ST_DROP;
      end
      ST_DROP:
        nxt_state = ST_CLOSE_WAIT;
      ST_CLOSE_WAIT:
      begin
        if (CLOSE_RESPONSE)
          nxt_state = ST_DRAIN;
      end
      ST_DRAIN:
      begin
        if (!CLOSE_RESPONSE)
          nxt_state = ST_CLOSE_WAIT;
        else if (tx_empty && !TX_WRITE)
          nxt_state = ST_LAST;
      end
      ST_LAST:
      begin
        if (NET_FIN_ACKED)
          nxt_state = ST_IDLE;
      end
      default:
        nxt_state = ST_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
      state_ff <= ST_IDLE;
    else
      state_ff <= nxt_state;
  end

  // Open drops one cycle before close request rises
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      open_ff <= 1'b0;
      close_req_ff <= 1'b0;
    end
    else
    begin
      open_ff <= (nxt_state == ST_OPEN);
      close_req_ff <= (nxt_state == ST_CLOSE_WAIT) || (nxt_state == ST_DRAIN) ||
                      (nxt_state == ST_LAST);
    end
  end

  // Termination confirmation pulse once drained
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
      fin_ff <= 1'b0;
    else
      fin_ff <= (state_ff == ST_DRAIN) && (nxt_state == ST_LAST);
  end

  assign CONNECTION_OPEN = open_ff;
  assign CLOSE_REQUEST = close_req_ff;
  assign NET_FIN_SEND = fin_ff;

  // Transmit writes taken while open, or while closing is pending
  assign tx_accept = TX_WRITE && tx_in_ready &&
                     ((state_ff == ST_OPEN) ||
                      (state_ff == ST_CLOSE_WAIT) || (state_ff == ST_DRAIN));

  byte_fifo #(
    .WIDTH(BYTE_W),
    .DEPTH(TX_DEPTH)
  ) u_tx_fifo (
    .clk(CLK_SYS),
    .rst(RST),
    .in_valid(tx_accept),
    .in_ready(tx_in_ready),
    .in_data(TX_BYTE),
    .out_valid(tx_out_valid),
    .out_ready(NET_TX_READY),
    .out_data(tx_out_data),
    .level(tx_level)
  );

  assign tx_empty = !tx_out_valid;
  assign tx_pop = tx_out_valid && NET_TX_READY;
  assign NET_TX_DATA = tx_out_data;
  assign NET_TX_VALID = tx_out_valid;

  // Full leaves room for writes during the stop allowance
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
      tx_full_ff <= 1'b0;
    else
      tx_full_ff <= (tx_level >= FULL_LEVEL);
  end

  assign TX_BUFFER_FULL = tx_full_ff;

  // Sticky flag for writes not taken, for lack of room or outside open and closing; set wins over clear
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
      tx_ovf_ff <= 1'b0;
    else if (TX_WRITE && !tx_accept)
      tx_ovf_ff <= 1'b1;
    else if (ovf_clear)
      tx_ovf_ff <= 1'b0;
  end

  // Receive bytes staged in a small buffer
  byte_fifo #(
    .WIDTH(BYTE_W),
    .DEPTH(RX_DEPTH)
  ) u_rx_fifo (
    .clk(CLK_SYS),
    .rst(RST),
    .in_valid(NET_RX_VALID),
    .in_ready(NET_RX_READY),
    .in_data(NET_RX_DATA),
    .out_valid(rx_out_valid),
    .out_ready(rx_out_ready),
    .out_data(rx_out_data),
    .level(rx_level)
  );

  // Release to the user only while open and room is left
  assign rx_out_ready = (state_ff == ST_OPEN) && (window_ff != 16'h0000);
  assign rx_release = rx_out_valid && rx_out_ready;

  // Received byte and valid pulse from flops, arrival order kept
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      rx_byte_ff <= 8'h00;
      rx_valid_ff <= 1'b0;
    end
    else
    begin
      rx_valid_ff <= rx_release;
      if (rx_release)
        rx_byte_ff <= rx_out_data;
    end
  end

  assign RX_BYTE = rx_byte_ff;
  assign RX_VALID = rx_valid_ff;

  // Bytes handed out whose count may not yet show
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
      rx_hist_ff <= '0;
    else
      rx_hist_ff <= {rx_hist_ff[WC_LAG_CLOCKS-2:0], rx_release};
  end

  // Count bits in use; forced ones above them are ignored
  assign wc_mask = width_mask(cfg.wc_width);
  assign wc_stored = RX_STORED_COUNT & wc_mask;

  // Free space: buffer size less stored, unconfirmed and staged bytes
  always_comb
  begin
    used_total = 18'(wc_stored) + 18'(ones(rx_hist_ff)) + 18'(rx_level);
    if (used_total >= 18'(wc_mask))
      nxt_window = 16'h0000;
    else
      nxt_window = 16'(18'(wc_mask) - used_total);
  end

  // Advertised window register
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
      window_ff <= 16'h0000;
    else
      window_ff <= nxt_window;
  end

  assign NET_RX_WINDOW = window_ff;
  assign NET_MSS = cfg.mss;

  // Traffic counters for software
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      tx_bytes_ff <= 32'h0000_0000;
      rx_bytes_ff <= 32'h0000_0000;
    end
    else
    begin
      if (tx_pop)
        tx_bytes_ff <= tx_bytes_ff + 32'h0000_0001;
      if (rx_release)
        rx_bytes_ff <= rx_bytes_ff + 32'h0000_0001;
    end
  end

  // Status gathered for the register port
  assign stat.tx_level = tx_level;
  assign stat.tx_overflow = tx_ovf_ff;
  assign stat.close_req = close_req_ff;
  assign stat.open = open_ff;
  assign stat.state = state_ff;

  tcp_reg_bank u_regs (
    .clk(CLK_SYS),
    .rst(RST),
    .addr(REG_ADDR),
    .wdata(REG_WDATA),
    .write(REG_WRITE),
    .read(REG_READ),
    .stat(stat),
    .tx_bytes(tx_bytes_ff),
    .rx_bytes(rx_bytes_ff),
    .rdata(REG_RDATA),
    .cfg(cfg),
    .ovf_clear(ovf_clear)
  );

endmodule : tcp_user_stream

`default_nettype wire

// file: sim/tb_top.sv
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import tcp_stream_pkg::*;
  logic clk_sys, rst, conn_open, close_req, close_resp, tx_write, tx_full, rx_valid;
  logic est, fin_rx, fin_send, fin_ack, ntx_valid, ntx_ready, nrx_valid, nrx_ready;
  logic reg_we, reg_re, start;
  logic [7:0] tx_byte, rx_byte, ntx_data, nrx_data, reg_addr, send_len;
  logic [15:0] rx_count, window, mss;
  logic [31:0] reg_wdata, reg_rdata;
  logic [7:0] txq[$];
  logic [7:0] rxq[$];
  int err_count, cmp_count, cycles;

  tcp_user_stream #(.TX_DEPTH(32), .RX_DEPTH(8)) i_tcp_user_stream (
    .CLK_SYS(clk_sys), .RST(rst), .CONNECTION_OPEN(conn_open), .CLOSE_REQUEST(close_req),
    .CLOSE_RESPONSE(close_resp), .TX_BYTE(tx_byte), .TX_WRITE(tx_write),
    .TX_BUFFER_FULL(tx_full), .RX_BYTE(rx_byte), .RX_VALID(rx_valid),
    .RX_STORED_COUNT(rx_count), .NET_ESTABLISHED(est), .NET_FIN_RECEIVED(fin_rx),
    .NET_FIN_SEND(fin_send), .NET_FIN_ACKED(fin_ack), .NET_TX_DATA(ntx_data),
    .NET_TX_VALID(ntx_valid), .NET_TX_READY(ntx_ready), .NET_RX_DATA(nrx_data),
    .NET_RX_VALID(nrx_valid), .NET_RX_READY(nrx_ready), .NET_RX_WINDOW(window),
    .NET_MSS(mss), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WRITE(reg_we),
    .REG_READ(reg_re), .REG_RDATA(reg_rdata));

  user_side_model i_user_side_model (
    .clk(clk_sys), .rst(rst), .start(start), .send_len(send_len),
    .connection_open(conn_open), .close_request(close_req), .close_response(close_resp),
    .tx_byte(tx_byte), .tx_write(tx_write), .tx_buffer_full(tx_full),
    .rx_valid(rx_valid), .rx_stored_count(rx_count));

  // Clock generation
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge clk_sys);
    reg_we <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge clk_sys);
    reg_re <= 1'b0;
    #1;
    check(reg_rdata, exp);
  endtask : reg_rd

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : stop_test

  // Engine-side transmit and user-side receive collectors, and hang limit
  always @(posedge clk_sys)
  begin
    cycles++;
    if (ntx_valid && ntx_ready)
      txq.push_back(ntx_data);
    if (rx_valid)
      rxq.push_back(rx_byte);
    if (cycles == 3000)
    begin
      err_count++;
      stop_test();
    end
  end

  // Main sequence
  initial
  begin
    {rst, est, fin_rx, fin_ack, ntx_ready, nrx_valid, reg_we, reg_re, start} = 9'h100;
    {nrx_data, reg_addr, send_len, reg_wdata} = 56'h0;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    #1;
    check(conn_open, 1'b0);
    check(mss, 16'h05B4);
    reg_rd(OFS_MSS, 32'h000005B4);
    reg_rd(8'h20, 32'h00000000);
    reg_wr(OFS_MSS, 32'h00000400);
    @(posedge clk_sys);
    #1;
    check(mss, 16'h0400);
    reg_wr(OFS_MSS, 32'h000005B4);
    $display("test registers done");
    @(posedge clk_sys) est <= 1'b1;
    @(posedge clk_sys) est <= 1'b0;
    @(posedge clk_sys);
    #1;
    check(conn_open, 1'b1);
    check(window, 16'hFFFF);
    $display("test connect done");
    @(posedge clk_sys)
    begin
      send_len <= 8'h1E;
      start <= 1'b1;
    end
    @(posedge clk_sys) start <= 1'b0;
    for (int i = 0; i < 40 && tx_full !== 1'b1; i++) @(posedge clk_sys);
    repeat (10) @(posedge clk_sys);
    #1;
    check(tx_full, 1'b1);
    check(tx_write, 1'b0);
    // Open state, open flag, 24 bytes held after the late writes
    reg_rd(OFS_STATUS, 32'h00180011);
    ntx_ready <= 1'b1;
    for (int i = 0; i < 80 && txq.size() < 30; i++) @(posedge clk_sys);
    check(txq.size(), 30);
    for (int i = 0; i < txq.size(); i++) check(txq[i], i);
    #1;
    check(tx_full, 1'b0);
    reg_rd(OFS_TX_BYTES, 32'h0000001E);
    $display("test transmit done");
    for (int i = 0; i < 12; i++)
    begin
      nrx_data <= 8'hA0 + i[7:0];
      nrx_valid <= 1'b1;
      do @(negedge clk_sys); while (nrx_ready !== 1'b1);
      @(posedge clk_sys);
    end
    nrx_valid <= 1'b0;
    for (int i = 0; i < 40 && rxq.size() < 12; i++) @(posedge clk_sys);
    check(rxq.size(), 12);
    for (int i = 0; i < rxq.size(); i++) check(rxq[i], 8'hA0 + i);
    repeat (16) @(posedge clk_sys);
    #1;
    check(window, 16'hFFF3);
    reg_rd(OFS_RX_BYTES, 32'h0000000C);
    // Four count bits: capacity 15 less the 12 stored
    reg_wr(OFS_CTRL, 32'h00000004);
    reg_rd(OFS_CTRL, 32'h00000004);
    @(posedge clk_sys);
    #1;
    check(window, 16'h0003);
    // Width above 16 is clamped back to 16
    reg_wr(OFS_CTRL, 32'h0000001F);
    reg_rd(OFS_CTRL, 32'h00000010);
    $display("test receive done");
    @(posedge clk_sys) fin_rx <= 1'b1;
    @(posedge clk_sys) fin_rx <= 1'b0;
    for (int i = 0; i < 30 && fin_send !== 1'b1; i++) @(posedge clk_sys) #1;
    check(fin_send, 1'b1);
    check(close_req, 1'b1);
    check(conn_open, 1'b0);
    @(posedge clk_sys) fin_ack <= 1'b1;
    @(posedge clk_sys) fin_ack <= 1'b0;
    @(posedge clk_sys);
    #1;
    check(close_req, 1'b0);
    $display("test close done");
    stop_test();
  end
endmodule : tb_top

bind tcp_user_stream tcp_stream_sva i_tcp_stream_sva (
  .CLK_SYS, .RST, .CONNECTION_OPEN, .CLOSE_REQUEST, .CLOSE_RESPONSE, .TX_WRITE,
  .TX_BUFFER_FULL, .RX_VALID, .NET_ESTABLISHED, .NET_FIN_RECEIVED, .NET_FIN_SEND,
  .NET_FIN_ACKED, .NET_TX_DATA, .NET_TX_VALID, .NET_TX_READY);

`default_nettype wire

// file: sim/tcp_stream_sva.sv
`default_nettype none

module tcp_stream_sva (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic CONNECTION_OPEN,
  input wire logic CLOSE_REQUEST,
  input wire logic CLOSE_RESPONSE,
  input wire logic TX_WRITE,
  input wire logic TX_BUFFER_FULL,
  input wire logic RX_VALID,
  input wire logic NET_ESTABLISHED,
  input wire logic NET_FIN_RECEIVED,
  input wire logic NET_FIN_SEND,
  input wire logic NET_FIN_ACKED,
  input wire logic [7:0] NET_TX_DATA,
  input wire logic NET_TX_VALID,
  input wire logic NET_TX_READY
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sent_ff;
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (RST);
  // Remembers a confirmation sent during this close
  always_ff @(posedge CLK_SYS or posedge RST)
    if (RST)
      sent_ff <= 1'b0;
    else if (NET_FIN_SEND)
      sent_ff <= 1'b1;
    else if (!CLOSE_REQUEST)
      sent_ff <= 1'b0;
  // Teardown steps: open falls, then request rises
  sequence s_teardown;
    !CONNECTION_OPEN ##1 CLOSE_REQUEST;
  endsequence
  a_open_drops: assert property (
    CONNECTION_OPEN && NET_FIN_RECEIVED |=> s_teardown)
    else $error("teardown order wrong");
  a_req_closed: assert property (
    CLOSE_REQUEST |-> !CONNECTION_OPEN)
    else $error("open high during close request");
  a_open_rises: assert property (
    NET_ESTABLISHED && !CONNECTION_OPEN && !CLOSE_REQUEST && !$past(CONNECTION_OPEN)
    |=> CONNECTION_OPEN)
    else $error("open did not rise");
  a_fin_drained: assert property (
    NET_FIN_SEND |-> $past(CLOSE_RESPONSE) && !$past(TX_WRITE) && !$past(NET_TX_VALID))
    else $error("confirmation before transmit drained");
  a_fin_pulse: assert property (
    NET_FIN_SEND |-> CLOSE_REQUEST ##1 !NET_FIN_SEND)
    else $error("confirmation not a single pulse");
  a_ack_closes: assert property (
    sent_ff && NET_FIN_ACKED |=> !CLOSE_REQUEST)
    else $error("close request stuck after ack");
  a_rx_in_open: assert property (
    RX_VALID |-> $past(CONNECTION_OPEN))
    else $error("receive byte outside open");
  a_tx_holds: assert property (
    NET_TX_VALID && !NET_TX_READY |=> NET_TX_VALID && $stable(NET_TX_DATA))
    else $error("transmit byte not held");
  a_tx_taken: assert property (
    TX_WRITE && CONNECTION_OPEN && !TX_BUFFER_FULL |=> NET_TX_VALID)
    else $error("written byte not forwarded");
endmodule : tcp_stream_sva

`default_nettype wire

// file: sim/user_side_model.sv
`default_nettype none

module user_side_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [7:0] send_len,
  input wire logic connection_open,
  input wire logic close_request,
  output logic close_response,
  output logic [7:0] tx_byte,
  output logic tx_write,
  input wire logic tx_buffer_full,
  input wire logic rx_valid,
  output logic [15:0] rx_stored_count
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] left_ff;
  logic go;
  // Response tied to request, so it stands while request stands
  assign close_response = close_request;
  // Write only while open, not full and not closing
  assign go = (left_ff != 8'h00) && connection_open && !tx_buffer_full && !close_request;
  // Counting byte source
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      left_ff <= 8'h00;
      tx_write <= 1'b0;
      tx_byte <= 8'hFF;
    end
    else
    begin
      tx_write <= go;
      if (start)
        left_ff <= send_len;
      else if (go)
        left_ff <= left_ff - 8'h01;
      if (go)
        tx_byte <= tx_byte + 8'h01;
    end
  // Receive buffer fill, all 16 count bits in use
  always_ff @(posedge clk or posedge rst)
    if (rst)
      rx_stored_count <= 16'h0000;
    else if (rx_valid)
      rx_stored_count <= rx_stored_count + 16'h0001;
endmodule : user_side_model

`default_nettype wire
